// >>> rtl/gpio_fast_map.vh
// register offsets and reset values for the parallel port with fast access
// assumes both access paths address registers by word index, byte enables select lanes
`ifndef GPIO_FAST_MAP_VH
`define GPIO_FAST_MAP_VH
// legacy group word offsets
`define LEG_PIN 3'h0
`define LEG_SET 3'h1
`define LEG_DIR 3'h2
`define LEG_CLR 3'h3
// fast group word offsets
`define FST_DIR 3'h0
`define FST_MASK 3'h4
`define FST_PIN 3'h5
`define FST_SET 3'h6
`define FST_CLR 3'h7
// reset values
`define RST_DIR 32'h00000000
`define RST_OUT 32'h00000000
`define RST_MASK 32'h00000000
`endif

// >>> rtl/gpio_fast_port.v
// one parallel port with a legacy peripheral-bus group and a fast local-bus group
// assumes pins are sampled asynchronously; peripheral selection is a per-bit input
`include "gpio_fast_map.vh"
`default_nettype none

module gpio_fast_port #(
    parameter WIDTH = 32
) (
    // clock, reset, enable
    input wire sys_clk,
    input wire resetn,
    input wire clkEn,
    // configuration: 1 selects fast group, 0 legacy
    input wire fastSel,
    // legacy peripheral bus
    input wire legSel,
    input wire legWr,
    input wire [2:0] legAddr,
    input wire [WIDTH-1:0] legWdata,
    output reg [WIDTH-1:0] legRdata_r,
    output reg legAck_r,
    // fast local bus
    input wire fstSel,
    input wire fstWr,
    input wire [2:0] fstAddr,
    input wire [WIDTH/8-1:0] fstBe,
    input wire [WIDTH-1:0] fstWdata,
    output reg [WIDTH-1:0] fstRdata_r,
    output reg fstAck_r,
    // peripheral claim and pins
    input wire [WIDTH-1:0] periphOwn,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] pinOut_r,
    output reg [WIDTH-1:0] pinOe_r
);

// architectural state and its next values
reg [WIDTH-1:0] dir_r;
reg [WIDTH-1:0] dir_nxt;
reg [WIDTH-1:0] out_r;
reg [WIDTH-1:0] out_nxt;
reg [WIDTH-1:0] mask_r;
reg [WIDTH-1:0] mask_nxt;

// pin input conditioning
reg [WIDTH-1:0] sync1_r;
reg [WIDTH-1:0] sync2_r;
reg [WIDTH-1:0] sync3_r;
reg [WIDTH-1:0] pinState_r;
wire [WIDTH-1:0] pinState_nxt;

// read multiplexers and registered response values
reg [WIDTH-1:0] legRd;
reg [WIDTH-1:0] fstRd;
wire [WIDTH-1:0] legRdata_nxt;
wire [WIDTH-1:0] fstRdata_nxt;
wire legAck_nxt;
wire fstAck_nxt;

// pin drive next values
wire [WIDTH-1:0] pinOut_nxt;
wire [WIDTH-1:0] pinOe_nxt;

// fast write lane selection
wire [WIDTH-1:0] beMask;
wire [WIDTH-1:0] wsel;

// the inactive group is not heard at all: no ack, no effect
wire legGo = legSel & ~fastSel;
wire fstGo = fstSel & fastSel;
wire legWrGo = legGo & legWr;
wire legRdGo = legGo & ~legWr;
wire fstWrGo = fstGo & fstWr;
wire fstRdGo = fstGo & ~fstWr;

// legacy write strobes, one per mapped word
wire legWrPin = legWrGo & (legAddr == `LEG_PIN);
wire legWrSet = legWrGo & (legAddr == `LEG_SET);
wire legWrDir = legWrGo & (legAddr == `LEG_DIR);
wire legWrClr = legWrGo & (legAddr == `LEG_CLR);

// fast write strobes; unmapped words raise no strobe and change nothing
wire fstWrDir = fstWrGo & (fstAddr == `FST_DIR);
wire fstWrMask = fstWrGo & (fstAddr == `FST_MASK);
wire fstWrPin = fstWrGo & (fstAddr == `FST_PIN);
wire fstWrSet = fstWrGo & (fstAddr == `FST_SET);
wire fstWrClr = fstWrGo & (fstAddr == `FST_CLR);

// byte lanes widened to a bit mask; WIDTH must be a multiple of eight
genvar lane;
generate
    for (lane = 0; lane < WIDTH / 8; lane = lane + 1) begin : g_lane
        assign beMask[lane*8 +: 8] = {8{fstBe[lane]}};
    end
endgenerate

// a fast direction or output write touches a bit only if its lane is on and its mask bit is clear
assign wsel = beMask & ~mask_r;

// direction next value
always @* begin
    dir_nxt = dir_r;
    if (legWrDir) begin
        dir_nxt = legWdata;
    end
    if (fstWrDir) begin
        dir_nxt = (dir_r & ~wsel) | (fstWdata & wsel);
    end
end

// output latch next value; the two groups never write in one cycle
always @* begin
    out_nxt = out_r;
    if (legWrPin) begin
        // a legacy write to the pin word loads the whole latch
        out_nxt = legWdata;
    end
    if (legWrSet) begin
        out_nxt = out_r | legWdata;
    end
    if (legWrClr) begin
        out_nxt = out_r & ~legWdata;
    end
    if (fstWrPin) begin
        out_nxt = (out_r & ~wsel) | (fstWdata & wsel);
    end
    if (fstWrSet) begin
        out_nxt = out_r | (fstWdata & wsel);
    end
    if (fstWrClr) begin
        out_nxt = out_r & ~(fstWdata & wsel);
    end
end

// mask next value; the mask cannot protect itself, only lanes gate it
always @* begin
    mask_nxt = mask_r;
    if (fstWrMask) begin
        mask_nxt = (mask_r & ~beMask) | (fstWdata & beMask);
    end
end

// legacy read multiplexer
always @* begin
    case (legAddr)
        `LEG_PIN: begin
            legRd = pinState_r;
        end
        `LEG_SET: begin
            legRd = out_r;
        end
        `LEG_DIR: begin
            legRd = dir_r;
        end
        `LEG_CLR: begin
            legRd = out_r;
        end
        default: begin
            legRd = {WIDTH{1'b0}};
        end
    endcase
end

// fast read multiplexer
always @* begin
    case (fstAddr)
        `FST_DIR: begin
            fstRd = dir_r;
        end
        `FST_MASK: begin
            fstRd = mask_r;
        end
        `FST_PIN: begin
            // masked bits read as zero so a group read needs no software masking
            fstRd = pinState_r & ~mask_r;
        end
        `FST_SET: begin
            fstRd = out_r;
        end
        `FST_CLR: begin
            fstRd = out_r;
        end
        default: begin
            fstRd = {WIDTH{1'b0}};
        end
    endcase
end

// responses: ack one cycle after the access, data zero unless a read is answered
assign legAck_nxt = legGo;
assign fstAck_nxt = fstGo;
assign legRdata_nxt = legRdGo ? legRd : {WIDTH{1'b0}};
assign fstRdata_nxt = fstRdGo ? (fstRd & beMask) : {WIDTH{1'b0}};

// claimed pins are left to the peripheral mux, never driven from here
assign pinOut_nxt = out_nxt & ~periphOwn;
assign pinOe_nxt = dir_nxt & ~periphOwn;

// a bit changes only once stages two and three agree, otherwise it holds
assign pinState_nxt = (sync2_r & sync3_r) | (pinState_r & (sync2_r | sync3_r));

// state registers, one process each except the three synchroniser stages, which share one; a low clock enable freezes them all
// direction: every bit comes out of reset as an input
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        dir_r <= `RST_DIR;
    end else if (clkEn) begin
        dir_r <= dir_nxt;
    end
end

// mask register
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        mask_r <= `RST_MASK;
    end else if (clkEn) begin
        mask_r <= mask_nxt;
    end
end

// output latch
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        out_r <= `RST_OUT;
    end else if (clkEn) begin
        out_r <= out_nxt;
    end
end

// pin synchroniser; the first stage feeds only the second
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        sync1_r <= {WIDTH{1'b0}};
        sync2_r <= {WIDTH{1'b0}};
        sync3_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        sync1_r <= pinIn;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end
end

// filtered pin state
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        pinState_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        pinState_r <= pinState_nxt;
    end
end

// legacy acknowledge
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        legAck_r <= 1'b0;
    end else if (clkEn) begin
        legAck_r <= legAck_nxt;
    end
end

// legacy read data
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        legRdata_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        legRdata_r <= legRdata_nxt;
    end
end

// fast acknowledge, one cycle after the local-bus access
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        fstAck_r <= 1'b0;
    end else if (clkEn) begin
        fstAck_r <= fstAck_nxt;
    end
end

// fast read data
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        fstRdata_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        fstRdata_r <= fstRdata_nxt;
    end
end

// pin drive levels follow the latch in the same edge as the write
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        pinOut_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        pinOut_r <= pinOut_nxt;
    end
end

// pin enables; nothing is driven until software sets a direction
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        pinOe_r <= {WIDTH{1'b0}};
    end else if (clkEn) begin
        pinOe_r <= pinOe_nxt;
    end
end

endmodule // gpio_fast_port
`default_nettype wire

// >>> dv/pin_board_model.sv
// board model: resolves each pin from port drive and external level
// assumes pinOe high means the port drives that pin
`default_nettype none
module pin_board_model (
    input wire logic [31:0] oe, drv, ext,
    output logic [31:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin = (oe & drv) | (~oe & ext);
endmodule // pin_board_model
`default_nettype wire

// >>> dv/gpio_fast_port_checker.sv
// checker: ack timing, set and clear effect, pin ownership
// assumes binding onto gpio_fast_port, one clock domain
`default_nettype none
module gpio_fast_port_checker #(parameter WIDTH = 32) (
    input wire logic sys_clk, resetn, clkEn, fastSel, legSel, legWr, legAck_r, fstSel, fstAck_r,
    input wire logic [2:0] legAddr,
    input wire logic [WIDTH-1:0] legWdata, legRdata_r, periphOwn, pinOut_r, pinOe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic legTaken = legSel && !fastSel && clkEn;
    a_leg_ack: assert property (legTaken |=> legAck_r) else $error("legacy ack");
    a_fst_ack: assert property (fstSel && fastSel && clkEn |=> fstAck_r) else $error("fast ack");
    a_no_ack: assert property (clkEn && !legTaken |=> !legAck_r) else $error("stray ack");
    a_rd_idle: assert property (!legAck_r |-> legRdata_r == 0) else $error("rdata idle");
    a_set_bits: assert property (legTaken && legWr && legAddr == 3'h1
        |=> (~pinOut_r & $past(legWdata & ~periphOwn)) == 0) else $error("set");
    a_clr_bits: assert property (legTaken && legWr && legAddr == 3'h3
        |=> (pinOut_r & $past(legWdata)) == 0) else $error("clear");
    a_oe_own: assert property (clkEn |=> (pinOe_r & $past(periphOwn)) == 0) else $error("own");
    a_rst_in: assert property ($rose(resetn) |-> pinOe_r == 0) else $error("reset dir");
endmodule // gpio_fast_port_checker
bind gpio_fast_port gpio_fast_port_checker #(.WIDTH(WIDTH)) i_gpio_fast_port_checker (.*);
`default_nettype wire

// >>> dv/gpio_fast_port_tb_top.sv
// testbench: legacy and fast access, peripheral claim, reset state
// assumes board model and checker compiled first
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module gpio_fast_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, resetn = 0, clkEn = 1, fastSel = 0, legSel = 0, legWr = 0, fstSel = 0;
    logic fstWr = 0, legAck_r, fstAck_r;
    logic [2:0] legAddr = 0, fstAddr = 0;
    logic [3:0] fstBe = 0;
    logic [31:0] legWdata = 0, fstWdata = 0, periphOwn = 0, ext = 0, pinIn;
    logic [31:0] legRdata_r, fstRdata_r, pinOut_r, pinOe_r;
    int error_cnt = 0, samples_checked = 0;
    gpio_fast_port i_gpio_fast_port (
        .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .fastSel(fastSel),
        .legSel(legSel), .legWr(legWr), .legAddr(legAddr), .legWdata(legWdata),
        .legRdata_r(legRdata_r), .legAck_r(legAck_r),
        .fstSel(fstSel), .fstWr(fstWr), .fstAddr(fstAddr), .fstBe(fstBe),
        .fstWdata(fstWdata), .fstRdata_r(fstRdata_r), .fstAck_r(fstAck_r),
        .periphOwn(periphOwn), .pinIn(pinIn), .pinOut_r(pinOut_r), .pinOe_r(pinOe_r)
    );
    pin_board_model i_pin_board_model (.oe(pinOe_r), .drv(pinOut_r), .ext(ext), .pin(pinIn));
    initial forever #5 sys_clk = ~sys_clk;
    task acc(input f, w, input [2:0] a, input [3:0] be, input [31:0] d, exp);
        @(posedge sys_clk);
        {fastSel, legSel, fstSel, legWr, fstWr} <= {f, !f, f, w, w};
        {legAddr, fstAddr, fstBe, legWdata, fstWdata} <= {a, a, be, d, d};
        @(posedge sys_clk);
        {legSel, fstSel} <= 2'h0;
        #1 `CHK("ack", 1'h1, f ? fstAck_r : legAck_r)
        if (!w) `CHK("rdata", exp, f ? fstRdata_r : legRdata_r)
    endtask
    task t_legacy;
        ext <= 32'h12345600;
        acc(0, 1, 3'h2, 4'hf, 32'hff, 0);
        acc(0, 1, 3'h1, 4'hf, 32'h0f, 0);
        acc(0, 1, 3'h3, 4'hf, 32'h05, 0);
        acc(0, 0, 3'h1, 4'hf, 0, 32'h0a);
        repeat (5) @(posedge sys_clk);
        acc(0, 0, 3'h0, 4'hf, 0, 32'h1234560a);
        `CHK("oe", 32'hff, pinOe_r)
    endtask
    task t_fast;
        acc(1, 1, 3'h4, 4'hf, 32'hffff0000, 0);
        acc(1, 1, 3'h5, 4'hf, 32'ha5a5a5a5, 0);
        acc(1, 1, 3'h6, 4'h2, 32'hffffffff, 0);
        acc(1, 0, 3'h6, 4'h1, 0, 32'ha5);
        `CHK("out", 32'hffa5, pinOut_r)
    endtask
    task t_claim;
        @(posedge sys_clk);
        periphOwn <= 32'hf0;
        @(posedge sys_clk);
        #1 `CHK("oe", 32'h0f, pinOe_r)
        `CHK("out", 32'hff05, pinOut_r)
    endtask
    // inactive group and frozen enable must both leave the port untouched
    task t_refuse;
        @(posedge sys_clk);
        {fastSel, legSel, legWr, legAddr, legWdata} <= {1'b1, 1'b1, 1'b1, 3'h3, 32'hffffffff};
        @(posedge sys_clk);
        legSel <= 1'b0;
        #1 `CHK("legack", 1'h0, legAck_r)
        acc(1, 0, 3'h6, 4'hf, 0, 32'hffa5);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        {fstSel, fstWr, fstAddr, fstBe, fstWdata} <= {1'b1, 1'b1, 3'h7, 4'hf, 32'hffffffff};
        @(posedge sys_clk);
        fstSel <= 1'b0;
        clkEn <= 1'b1;
        #1 `CHK("fstack", 1'h0, fstAck_r)
        acc(1, 0, 3'h6, 4'hf, 0, 32'hffa5);
        acc(1, 1, 3'h0, 4'hf, 32'h0000ffff, 0);
        `CHK("oe", 32'hff0f, pinOe_r)
        acc(1, 1, 3'h7, 4'hf, 32'h000000ff, 0);
        `CHK("out", 32'hff00, pinOut_r)
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1;
        `CHK("oe", 32'h0, pinOe_r)
        t_legacy;
        t_fast;
        t_claim;
        t_refuse;
        end_of_test;
    end
    // cut a hang short well beyond the roughly 41 cycles the run needs
    initial begin
        #5000;
        error_cnt++;
        end_of_test;
    end
endmodule // gpio_fast_port_tb_top
`default_nettype wire
